// ==== spal_core.sv ====
/*
 * Programming gatekeeper: decrypts an encrypted programming stream with
 * the stored 128-bit key, authenticates every word, and only then erases
 * and programs the configuration array. Also enforces the access pass key,
 * open-verify/open-read options, permanent settings and permanent lock.
 * Assumes a classic Wishbone master on clk_sys; srst is synchronous.
 */
// What this block does
// - Decrypt stream with 128-bit key, then authenticate
// - Authentication covers every word of stream
// - Authenticate decrypted data as valid for device
// - Running design continues during decrypt and check
// - Erase then program only after check passes
// - Failed check: no erase, design untouched
// - Key stored on-chip, never readable outside
// - Only same-key streams decrypt correctly
// - Wrong-key streams fail and are blocked
// - Pass key guards array, memory, settings
// - Option: verify or read without pass key
// - Permanent settings freeze all security settings
// - Permanent lock disables array and memory access
// - Verification happens only inside the device
`timescale 1ns/1ps
module spal_core (
	input  wire logic        clk_sys,
	input  wire logic        srst,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             irq,
	output logic             prog_busy,
	output logic      [31:0] design_cfg
);
	localparam int IRQW = spal_pkg::IRQ_W;
	spal_pkg::spal_state_t state;
	spal_pkg::spal_state_t next_state;

	logic [3:0][31:0] pass_in;
	logic [3:0][31:0] secret_stage;
	logic [127:0]     key_store;
	logic [127:0]     pass_key;
	logic             key_set;
	logic             pass_set;
	logic             perm_settings;
	logic             perm_lock;
	logic             opt_verify_open;
	logic             opt_read_open;
	logic [31:0]      array_mem [spal_pkg::ARRAY_DEPTH];
	logic [31:0]      shadow    [spal_pkg::ARRAY_DEPTH];
	logic [31:0]      nvm_mem   [spal_pkg::NVM_DEPTH];
	logic [4:0]       stream_len;
	logic [4:0]       idx;
	logic [4:0]       cnt;
	logic [31:0]      mac;
	logic             tag_ok;
	logic             mac_ok;
	logic             last_auth_ok;
	logic             verify_match;
	logic [31:0]      addr_reg;
	logic [31:0]      data_reg;
	logic [31:0]      result;
	logic [IRQW-1:0]  irq_stat;
	logic [IRQW-1:0]  irq_mask;
	logic [31:0]      rd_mux;
	logic             cmd_ok;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) r[8*b +: 8] = nw[8*b +: 8];
		end
		return r;
	endfunction

	// Keystream word for stream position i; uses only key word i mod 4, so the four key words take turns
	function automatic logic [31:0] keystream(input logic [127:0] k, input logic [4:0] i);
		logic [31:0] w;
		w = k[{i[1:0], 5'b00000} +: 32];
		return {w[26:0], w[31:27]} ^ {27'h0, i} ^ spal_pkg::KS_SALT;
	endfunction

	function automatic logic [31:0] mac_step(input logic [31:0] m, input logic [31:0] w, input logic [127:0] k);
		return {m[30:0], m[31]} ^ w ^ k[127:96];
	endfunction

	// Bus decode
	wire        req        = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire        wr         = req & wb_we_i;
	wire        rd         = req & ~wb_we_i;
	wire        cmd_go     = wr & (wb_adr_i == spal_pkg::OFF_CTRL) & wb_sel_i[0];
	wire [3:0]  cmd        = wb_dat_i[3:0];
	wire        stream_wr  = wr & (wb_adr_i == spal_pkg::OFF_STREAM) & (&wb_sel_i);
	wire        idle       = (state == spal_pkg::ST_IDLE);
	wire [31:0] plain      = wb_dat_i ^ keystream(key_store, idx);
	wire        pass_match = ({pass_in[3], pass_in[2], pass_in[1], pass_in[0]} == pass_key);
	wire        unlocked   = ~pass_set | pass_match;
	wire [127:0] secret_w  = {secret_stage[3], secret_stage[2], secret_stage[1], secret_stage[0]};

	// Access permissions
	wire sec_ok    = unlocked & ~perm_settings & ~perm_lock & idle;
	wire begin_ok  = unlocked & ~perm_lock & key_set & idle & (stream_len <= 5'(spal_pkg::ARRAY_DEPTH));
	wire verify_ok = (unlocked | opt_verify_open) & ~perm_lock & idle;
	wire nvm_rd_ok = (unlocked | opt_read_open) & ~perm_lock;
	wire nvm_wr_ok = unlocked & ~perm_lock & idle;
	wire last_word = (idx == stream_len + 5'd1);
	wire prog_end  = (state == spal_pkg::ST_PROGRAM) & (cnt == stream_len);
	wire erase_end = (state == spal_pkg::ST_ERASE) & (cnt == 5'(spal_pkg::ARRAY_DEPTH - 1));

	always_comb begin
		unique case (cmd)
			spal_pkg::CMD_BEGIN:     cmd_ok = begin_ok;
			spal_pkg::CMD_SET_KEY,
			spal_pkg::CMD_SET_PASS,
			spal_pkg::CMD_SET_OPTS,
			spal_pkg::CMD_PERM_SET,
			spal_pkg::CMD_PERM_LOCK: cmd_ok = sec_ok;
			spal_pkg::CMD_VERIFY:    cmd_ok = verify_ok;
			spal_pkg::CMD_NVM_WRITE: cmd_ok = nvm_wr_ok;
			spal_pkg::CMD_NVM_READ:  cmd_ok = nvm_rd_ok;
			spal_pkg::CMD_ABORT:     cmd_ok = (state == spal_pkg::ST_LOAD);
			default:                 cmd_ok = 1'b0;
		endcase
	end

	wire do_cmd  = cmd_go & cmd_ok;
	wire refused = (cmd_go & ~cmd_ok) | (stream_wr & (state != spal_pkg::ST_LOAD));

	// Loading and checking touch only the shadow buffer, so the running design is left alone
	always_comb begin
		next_state = state;
		unique case (state)
			spal_pkg::ST_IDLE: next_state = (do_cmd && cmd == spal_pkg::CMD_BEGIN) ? spal_pkg::ST_LOAD : state;
			spal_pkg::ST_LOAD: begin
				if (do_cmd && cmd == spal_pkg::CMD_ABORT) begin
					next_state = spal_pkg::ST_IDLE;
				end else if (stream_wr && last_word) begin
					next_state = spal_pkg::ST_CHECK;
				end
			end
			spal_pkg::ST_CHECK: begin
				next_state = mac_ok ? spal_pkg::ST_ERASE : spal_pkg::ST_IDLE;
			end
			spal_pkg::ST_ERASE:   next_state = erase_end ? spal_pkg::ST_PROGRAM : state;
			spal_pkg::ST_PROGRAM: next_state = prog_end ? spal_pkg::ST_IDLE : state;
			default: next_state = spal_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state <= spal_pkg::ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Stream decryption and running authentication code
	always_ff @(posedge clk_sys) begin
		if (srst || (do_cmd && cmd == spal_pkg::CMD_BEGIN)) begin
			idx    <= 5'd0;
			mac    <= spal_pkg::MAC_SEED;
			tag_ok <= 1'b0;
			mac_ok <= 1'b0;
		end else if (stream_wr && state == spal_pkg::ST_LOAD) begin
			idx <= idx + 5'd1;
			if (last_word) begin
				mac_ok <= tag_ok & (plain == mac);
			end else begin
				mac <= mac_step(mac, plain, key_store);
			end
			if (idx == 5'd0) begin
				tag_ok <= (plain == spal_pkg::DEVICE_TAG);
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (stream_wr && state == spal_pkg::ST_LOAD && idx != 5'd0 && !last_word) begin
			shadow[4'(idx - 5'd1)] <= plain;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst || state == spal_pkg::ST_CHECK || erase_end) begin
			cnt <= 5'd0;
		end else if (state == spal_pkg::ST_ERASE || (state == spal_pkg::ST_PROGRAM && !prog_end)) begin
			cnt <= cnt + 5'd1;
		end
	end

	// Reset stands in for the blank factory state of the nonvolatile stores
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			for (int i = 0; i < spal_pkg::ARRAY_DEPTH; i++) begin
				array_mem[i] <= spal_pkg::WORD_RST;
			end
		end else if (state == spal_pkg::ST_ERASE) begin
			array_mem[cnt[3:0]] <= spal_pkg::WORD_RST;
		end else if (state == spal_pkg::ST_PROGRAM && !prog_end) begin
			array_mem[cnt[3:0]] <= shadow[cnt[3:0]];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			for (int i = 0; i < spal_pkg::NVM_DEPTH; i++) begin
				nvm_mem[i] <= spal_pkg::WORD_RST;
			end
		end else if (do_cmd && cmd == spal_pkg::CMD_NVM_WRITE) begin
			nvm_mem[addr_reg[1:0]] <= data_reg;
		end
	end

	// Security settings
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			key_store       <= spal_pkg::KEY_RST;
			pass_key        <= spal_pkg::KEY_RST;
			key_set         <= 1'b0;
			pass_set        <= 1'b0;
			perm_settings   <= 1'b0;
			perm_lock       <= 1'b0;
			opt_verify_open <= 1'b0;
			opt_read_open   <= 1'b0;
		end else if (do_cmd) begin
			unique case (cmd)
				spal_pkg::CMD_SET_KEY: begin
					key_store <= secret_w;
					key_set   <= 1'b1;
				end
				spal_pkg::CMD_SET_PASS: begin
					pass_key <= secret_w;
					pass_set <= 1'b1;
				end
				spal_pkg::CMD_SET_OPTS: begin
					opt_verify_open <= data_reg[0];
					opt_read_open   <= data_reg[1];
				end
				spal_pkg::CMD_PERM_SET:  perm_settings <= 1'b1;
				spal_pkg::CMD_PERM_LOCK: perm_lock <= 1'b1;
				default: ;
			endcase
		end
	end

	// Presented pass key and secret staging words
	for (genvar g = 0; g < spal_pkg::KEY_WORDS; g++) begin : g_words
		always_ff @(posedge clk_sys) begin
			if (srst) begin
				pass_in[g]      <= spal_pkg::WORD_RST;
				secret_stage[g] <= spal_pkg::WORD_RST;
			end else if (wr && wb_adr_i == spal_pkg::OFF_PASS + 8'(4 * g)) begin
				pass_in[g] <= merge(pass_in[g], wb_dat_i, wb_sel_i);
			end else if (wr && wb_adr_i == spal_pkg::OFF_SECRET + 8'(4 * g)) begin
				secret_stage[g] <= merge(secret_stage[g], wb_dat_i, wb_sel_i);
			end
		end
	end

	// Plain registers and on-chip verify; a verify returns only a match bit, never the array word
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			stream_len   <= 5'd0;
			addr_reg     <= spal_pkg::WORD_RST;
			data_reg     <= spal_pkg::WORD_RST;
			result       <= spal_pkg::WORD_RST;
			verify_match <= 1'b0;
			last_auth_ok <= 1'b0;
		end else begin
			if (wr && wb_adr_i == spal_pkg::OFF_LEN && idle) stream_len <= wb_dat_i[4:0];
			if (wr && wb_adr_i == spal_pkg::OFF_ADDR) addr_reg <= merge(addr_reg, wb_dat_i, wb_sel_i);
			if (wr && wb_adr_i == spal_pkg::OFF_DATA) data_reg <= merge(data_reg, wb_dat_i, wb_sel_i);
			if (do_cmd && cmd == spal_pkg::CMD_VERIFY) begin
				verify_match <= (array_mem[addr_reg[3:0]] == data_reg);
				result       <= {31'h0, array_mem[addr_reg[3:0]] == data_reg};
			end else if (do_cmd && cmd == spal_pkg::CMD_NVM_READ) begin
				result <= nvm_mem[addr_reg[1:0]];
			end
			if (state == spal_pkg::ST_CHECK) last_auth_ok <= mac_ok;
		end
	end

	// Interrupts: a new event in the same cycle as the clearing read survives
	wire [IRQW-1:0] events = {prog_end, refused, (state == spal_pkg::ST_CHECK) & ~mac_ok,
		(state == spal_pkg::ST_CHECK) & mac_ok};
	wire stat_rd = rd & (wb_adr_i == spal_pkg::OFF_IRQ_STAT);
	wire [IRQW-1:0] next_irq_stat = (stat_rd ? '0 : irq_stat) | events;
	wire [IRQW-1:0] next_irq_mask = (wr && wb_adr_i == spal_pkg::OFF_IRQ_MASK) ? wb_dat_i[IRQW-1:0] : irq_mask;

	wire [31:0] status_w = {20'h0, verify_match, last_auth_ok, opt_read_open, opt_verify_open, perm_lock,
		perm_settings, unlocked, pass_set, key_set, state};

	// Key, pass key and secret staging words read as zero
	always_comb begin
		unique case (wb_adr_i)
			spal_pkg::OFF_STATUS:   rd_mux = status_w;
			spal_pkg::OFF_IRQ_STAT: rd_mux = {28'h0, irq_stat};
			spal_pkg::OFF_IRQ_MASK: rd_mux = {28'h0, irq_mask};
			spal_pkg::OFF_LEN:      rd_mux = {27'h0, stream_len};
			spal_pkg::OFF_ADDR:     rd_mux = addr_reg;
			spal_pkg::OFF_DATA:     rd_mux = data_reg;
			spal_pkg::OFF_RESULT:   rd_mux = result;
			default:                rd_mux = spal_pkg::WORD_RST;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			wb_ack_o   <= 1'b0;
			wb_dat_o   <= spal_pkg::WORD_RST;
			irq_stat   <= '0;
			irq_mask   <= '0;
			irq        <= 1'b0;
			prog_busy  <= 1'b0;
			design_cfg <= spal_pkg::WORD_RST;
		end else begin
			wb_ack_o   <= req;
			wb_dat_o   <= rd ? rd_mux : spal_pkg::WORD_RST;
			irq_stat   <= next_irq_stat;
			irq_mask   <= next_irq_mask;
			irq        <= |(next_irq_stat & next_irq_mask);
			prog_busy  <= (next_state == spal_pkg::ST_ERASE) || (next_state == spal_pkg::ST_PROGRAM);
			design_cfg <= array_mem[0];
		end
	end

	sequence s_check_fail;
		state == spal_pkg::ST_CHECK && !mac_ok;
	endsequence
	sequence s_check_pass;
		state == spal_pkg::ST_CHECK && mac_ok;
	endsequence

	ack_once_a: assert property (@(posedge clk_sys) disable iff (srst) wb_ack_o |=> !wb_ack_o)
		else $error("ack held for more than one cycle");
	key_hidden_a: assert property (@(posedge clk_sys) disable iff (srst)
		rd && wb_adr_i >= spal_pkg::OFF_PASS |=> wb_dat_o == 32'h0)
		else $error("secret area returned nonzero data");
	fail_keeps_a: assert property (@(posedge clk_sys) disable iff (srst)
		s_check_fail |=> state == spal_pkg::ST_IDLE ##1 design_cfg == $past(design_cfg, 2))
		else $error("failed check changed the design");
	pass_erases_a: assert property (@(posedge clk_sys) disable iff (srst)
		s_check_pass |=> state == spal_pkg::ST_ERASE ##0 prog_busy)
		else $error("passed check did not start erase");
	lock_idle_a: assert property (@(posedge clk_sys) disable iff (srst)
		perm_lock |-> state == spal_pkg::ST_IDLE || state == spal_pkg::ST_CHECK)
		else $error("array write in progress while locked");
	settings_frozen_a: assert property (@(posedge clk_sys) disable iff (srst)
		perm_settings |=> $stable(key_store) && $stable(pass_key) && perm_lock == $past(perm_lock))
		else $error("security settings changed after freeze");
	irq_level_a: assert property (@(posedge clk_sys) disable iff (srst)
		irq == |(irq_stat & irq_mask))
		else $error("interrupt output disagrees with status and mask");
	unlock_exact_a: assert property (@(posedge clk_sys) disable iff (srst)
		do_cmd && cmd == spal_pkg::CMD_SET_KEY |-> !pass_set || pass_match)
		else $error("key replaced without matching pass key");
	load_quiet_a: assert property (@(posedge clk_sys) disable iff (srst)
		state == spal_pkg::ST_LOAD ##1 state == spal_pkg::ST_LOAD |-> $stable(design_cfg) && !prog_busy)
		else $error("design disturbed during stream load");
endmodule

// ==== spal_pkg.sv ====
/*
 * Shared constants for the secure program and access lock block:
 * register offsets, command codes, interrupt bit positions,
 * reset values and storage sizes.
 * Assumes a classic Wishbone slave with 32-bit data and byte addresses.
 */
package spal_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL     = 8'h00;
	localparam logic [7:0] OFF_STATUS   = 8'h04;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h0c;
	localparam logic [7:0] OFF_LEN      = 8'h10;
	localparam logic [7:0] OFF_STREAM   = 8'h14;
	localparam logic [7:0] OFF_ADDR     = 8'h18;
	localparam logic [7:0] OFF_DATA     = 8'h1c;
	localparam logic [7:0] OFF_RESULT   = 8'h20;
	localparam logic [7:0] OFF_PASS     = 8'h30;
	localparam logic [7:0] OFF_SECRET   = 8'h40;

	// Commands written to the low nibble of the control register
	localparam logic [3:0] CMD_BEGIN      = 4'h1;
	localparam logic [3:0] CMD_SET_KEY    = 4'h2;
	localparam logic [3:0] CMD_SET_PASS   = 4'h3;
	localparam logic [3:0] CMD_SET_OPTS   = 4'h4;
	localparam logic [3:0] CMD_PERM_SET   = 4'h5;
	localparam logic [3:0] CMD_PERM_LOCK  = 4'h6;
	localparam logic [3:0] CMD_VERIFY     = 4'h7;
	localparam logic [3:0] CMD_NVM_WRITE  = 4'h8;
	localparam logic [3:0] CMD_NVM_READ   = 4'h9;
	localparam logic [3:0] CMD_ABORT      = 4'ha;

	// Interrupt status bit positions
	localparam int IRQ_AUTH_PASS = 0;
	localparam int IRQ_AUTH_FAIL = 1;
	localparam int IRQ_REFUSED   = 2;
	localparam int IRQ_PROG_DONE = 3;
	localparam int IRQ_W         = 4;

	// Storage sizes
	localparam int ARRAY_DEPTH = 16;
	localparam int NVM_DEPTH   = 4;
	localparam int KEY_WORDS   = 4;

	// Reset values and stream constants (tag and seed values are arbitrary)
	localparam logic [31:0] DEVICE_TAG = 32'h5a17_c0de;
	localparam logic [31:0] MAC_SEED   = 32'h0f1e_2d3c;
	localparam logic [31:0] KS_SALT    = 32'h9e37_79b9;
	localparam logic [31:0] WORD_RST   = 32'h0000_0000;
	localparam logic [127:0] KEY_RST   = 128'h0;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_LOAD    = 3'b001,
		ST_CHECK   = 3'b010,
		ST_ERASE   = 3'b011,
		ST_PROGRAM = 3'b100
	} spal_state_t;
endpackage

// ==== spal_programmer.sv ====
/* Programmer model: builds encrypted programming streams for the gatekeeper.
 * Assumes the bench carries each word over the register bus. */
`timescale 1ns/1ps
module spal_programmer;
	logic [31:0] words [0:17];

	function automatic logic [31:0] rotl(input logic [31:0] v, input int n);
		return (v << n) | (v >> (32 - n));
	endfunction

	// Tag, data words, then the code; a flip or a bad tag is only made on request
	task automatic make(input logic [127:0] key, input int len, input logic [31:0] base,
			input int flip, input logic [31:0] tag);
		logic [31:0] m;
		logic [31:0] p;
		m = spal_pkg::MAC_SEED;
		for (int k = 0; k <= len + 1; k++) begin
			p = (k == 0) ? tag : (k == len + 1) ? m : base + k;
			if (k <= len)
				m = rotl(m, 1) ^ p ^ key[127:96];
			words[k] = p ^ rotl(key[32 * (k % 4) +: 32], 5) ^ k ^ spal_pkg::KS_SALT;
			if (k == flip)
				words[k] = words[k] ^ 32'h0000_0100;
		end
	endtask
endmodule

// ==== spal_core_tb.sv ====
/* Self-checking bench for the gatekeeper: stream loads, locks and options.
 * Assumes spal_core with a one-cycle registered Wishbone acknowledge. */
`timescale 1ns/1ps
module spal_core_tb;
	localparam logic [127:0] KEY_A  = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
	localparam logic [127:0] KEY_B  = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3211;
	localparam logic [127:0] PASS_A = 128'h5555_aaaa_1234_8765_0f0f_f0f0_3c3c_c3c3;
	logic        clk_sys = 1'b0;
	logic        srst    = 1'b1;
	logic        wb_cyc  = 1'b0;
	logic        wb_stb  = 1'b0;
	logic        wb_we   = 1'b0;
	logic [7:0]  wb_adr  = 8'h00;
	logic [3:0]  wb_sel  = 4'h0;
	logic [31:0] wb_dat  = 32'h0;
	logic [31:0] q;
	wire  [31:0] wb_dat_o;
	wire  [31:0] design_cfg;
	wire         wb_ack_o;
	wire         irq;
	wire         prog_busy;
	int          miscompares;
	int          n_tests;
	int          busy_n;

	spal_core i_dut (.clk_sys(clk_sys), .srst(srst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq), .prog_busy(prog_busy),
		.design_cfg(design_cfg));
	spal_programmer i_prog ();

	always #10 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (prog_busy === 1'b1) busy_n++;

	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Request held until ack is sampled high, then released for one idle cycle
	task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] d);
		int i;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we  <= we;
		wb_adr <= adr;
		wb_sel <= 4'hf;
		wb_dat <= d;
		for (i = 0; i < 20; i++) begin
			@(posedge clk_sys);
			if (wb_ack_o === 1'b1)
				break;
		end
		q = wb_dat_o;
		if (i == 20) begin
			miscompares++;
			give_verdict();
		end
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we  <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a);
		bus(1'b0, a, 32'h0);
	endtask

	task automatic stage(input logic [7:0] base, input logic [127:0] v);
		for (int i = 0; i < 4; i++)
			wr(base + 8'(4 * i), v[32 * i +: 32]);
	endtask

	task automatic refused(input logic [3:0] c, input logic exp);
		wr(spal_pkg::OFF_CTRL, {28'h0, c});
		rd(spal_pkg::OFF_IRQ_STAT);
		chk("refused flag", q & 32'h4, exp ? 32'h4 : 32'h0);
	endtask

	task automatic do_reset;
		srst <= 1'b1;
		repeat (6) @(posedge clk_sys);
		srst <= 1'b0;
		@(posedge clk_sys);
		wr(spal_pkg::OFF_IRQ_MASK, 32'h1);
	endtask

	task automatic load(input logic [127:0] key, input int len, input logic [31:0] base,
			input int flip, input logic [31:0] tag, input logic ok);
		logic [31:0] old;
		old = design_cfg;
		busy_n = 0;
		i_prog.make(key, len, base, flip, tag);
		wr(spal_pkg::OFF_LEN, len);
		wr(spal_pkg::OFF_CTRL, {28'h0, spal_pkg::CMD_BEGIN});
		for (int k = 0; k <= len + 1; k++)
			wr(spal_pkg::OFF_STREAM, i_prog.words[k]);
		chk("design during check", design_cfg, old);
		for (int i = 0; i < 40; i++) begin
			rd(spal_pkg::OFF_STATUS);
			if (q[2:0] === spal_pkg::ST_IDLE)
				break;
		end
		if (q[2:0] !== spal_pkg::ST_IDLE) begin
			miscompares++;
			give_verdict();
		end
		chk("last auth", q & 32'h400, ok ? 32'h400 : 32'h0);
		chk("irq level", {31'h0, irq}, {31'h0, ok});
		rd(spal_pkg::OFF_IRQ_STAT);
		chk("auth events", q & 32'hb, ok ? 32'h9 : 32'h2);
		chk("busy cycles", busy_n, ok ? len + 17 : 0);
		chk("running design", design_cfg, ok ? base + 1 : old);
		chk("irq cleared", {31'h0, irq}, 32'h0);
	endtask

	task automatic t_reset;
		rd(spal_pkg::OFF_STATUS);
		chk("status reset", q, 32'h20);
		chk("design reset", design_cfg, 32'h0);
		stage(spal_pkg::OFF_SECRET, KEY_A);
		refused(spal_pkg::CMD_SET_KEY, 1'b0);
		rd(spal_pkg::OFF_SECRET);
		chk("key readback", q, 32'h0);
		rd(spal_pkg::OFF_SECRET + 8'h0c);
		chk("key readback", q, 32'h0);
		rd(8'hfc);
		chk("unmapped", q, 32'h0);
		$display("done t_reset");
	endtask

	task automatic t_streams;
		load(KEY_A, 2, 32'h1000, -1, spal_pkg::DEVICE_TAG, 1'b1);
		load(KEY_B, 2, 32'h7000, -1, spal_pkg::DEVICE_TAG, 1'b0);
		load(KEY_A, 3, 32'h7000, 2, spal_pkg::DEVICE_TAG, 1'b0);
		load(KEY_A, 2, 32'h7000, -1, 32'h5a17_c0df, 1'b0);
		load(KEY_A, 16, 32'h2000, -1, spal_pkg::DEVICE_TAG, 1'b1);
		wr(spal_pkg::OFF_LEN, 32'h2);
		wr(spal_pkg::OFF_CTRL, {28'h0, spal_pkg::CMD_BEGIN});
		wr(spal_pkg::OFF_CTRL, {28'h0, spal_pkg::CMD_ABORT});
		rd(spal_pkg::OFF_STATUS);
		chk("state after abort", {29'h0, q[2:0]}, {29'h0, spal_pkg::ST_IDLE});
		chk("design after abort", design_cfg, 32'h2001);
		$display("done t_streams");
	endtask

	task automatic t_access;
		wr(spal_pkg::OFF_ADDR, 32'h1);
		wr(spal_pkg::OFF_DATA, 32'hcafe_0001);
		refused(spal_pkg::CMD_NVM_WRITE, 1'b0);
		refused(spal_pkg::CMD_NVM_READ, 1'b0);
		rd(spal_pkg::OFF_RESULT);
		chk("memory read", q, 32'hcafe_0001);
		stage(spal_pkg::OFF_SECRET, PASS_A);
		refused(spal_pkg::CMD_SET_PASS, 1'b0);
		rd(spal_pkg::OFF_STATUS);
		chk("pass set, locked", q & 32'h38, 32'h18);
		refused(spal_pkg::CMD_BEGIN, 1'b1);
		refused(spal_pkg::CMD_SET_KEY, 1'b1);
		stage(spal_pkg::OFF_PASS, PASS_A ^ {1'b1, 127'h0});
		refused(spal_pkg::CMD_SET_KEY, 1'b1);
		stage(spal_pkg::OFF_PASS, PASS_A);
		wr(spal_pkg::OFF_DATA, 32'h1);
		refused(spal_pkg::CMD_SET_OPTS, 1'b0);
		stage(spal_pkg::OFF_PASS, 128'h0);
		wr(spal_pkg::OFF_ADDR, 32'h0);
		wr(spal_pkg::OFF_DATA, 32'h2001);
		refused(spal_pkg::CMD_VERIFY, 1'b0);
		rd(spal_pkg::OFF_STATUS);
		chk("verify match", q & 32'h800, 32'h800);
		refused(spal_pkg::CMD_NVM_READ, 1'b1);
		stage(spal_pkg::OFF_PASS, PASS_A);
		wr(spal_pkg::OFF_DATA, 32'h2);
		refused(spal_pkg::CMD_SET_OPTS, 1'b0);
		stage(spal_pkg::OFF_PASS, 128'h0);
		wr(spal_pkg::OFF_ADDR, 32'h1);
		refused(spal_pkg::CMD_VERIFY, 1'b1);
		refused(spal_pkg::CMD_NVM_READ, 1'b0);
		rd(spal_pkg::OFF_RESULT);
		chk("open memory read", q, 32'hcafe_0001);
		stage(spal_pkg::OFF_PASS, PASS_A);
		refused(spal_pkg::CMD_PERM_SET, 1'b0);
		refused(spal_pkg::CMD_SET_KEY, 1'b1);
		refused(spal_pkg::CMD_SET_PASS, 1'b1);
		load(KEY_A, 1, 32'h3000, -1, spal_pkg::DEVICE_TAG, 1'b1);
		$display("done t_access");
	endtask

	task automatic t_perm_lock;
		do_reset();
		stage(spal_pkg::OFF_SECRET, KEY_A);
		refused(spal_pkg::CMD_SET_KEY, 1'b0);
		refused(spal_pkg::CMD_PERM_LOCK, 1'b0);
		rd(spal_pkg::OFF_STATUS);
		chk("lock status", q & 32'h80, 32'h80);
		refused(spal_pkg::CMD_VERIFY, 1'b1);
		refused(spal_pkg::CMD_NVM_WRITE, 1'b1);
		refused(spal_pkg::CMD_NVM_READ, 1'b1);
		refused(spal_pkg::CMD_BEGIN, 1'b1);
		$display("done t_perm_lock");
	endtask

	initial begin
		do_reset();
		t_reset();
		t_streams();
		t_access();
		t_perm_lock();
		give_verdict();
	end
endmodule
